// File: verilog/evs_cfg.svh
`ifndef EVS_CFG_SVH
`define EVS_CFG_SVH

// Bit positions shared by the event latch and the enable mask
`define EVS_CMD_ERR_BIT 5
`define EVS_EXE_ERR_BIT 4
`define EVS_DEV_ERR_BIT 3
`define EVS_QRY_ERR_BIT 2
`define EVS_OP_DONE_BIT 0
// Bits 7, 6 and 1 are unused; the latch always reads them as zero, the mask keeps what is written
`define EVS_USED_BITS 8'h3d

// Reset values
`define EVS_MASK_RESET 8'h00
`define EVS_LATCH_RESET 8'h00
`define EVS_QUES_RESET 2'h0

// Event summary position in the status byte
`define EVS_STB_SUMMARY_BIT 5

// Questionable event bits held here
`define EVS_QUES_VOLT_BIT 0
`define EVS_QUES_CURR_BIT 1

// Error code series boundaries (code magnitude)
`define EVS_SER_CMD_LO 10'h064
`define EVS_SER_EXE_LO 10'h0c8
`define EVS_SER_DEV_LO 10'h12c
`define EVS_SER_QRY_LO 10'h190
`define EVS_SER_QRY_HI 10'h1f4

// Error queue
`define EVS_ERRQ_DEPTH 4
`define EVS_ERR_W 10

// Identification string separators
`define EVS_IDENT_SEP 8'h2c
`define EVS_IDENT_JOIN 8'h2d

`endif

// File: verilog/evs_pkg.sv
package evs_pkg;

  // Commands issued by the controller
  typedef enum logic [2:0] {
    evs_cmd_none,
    evs_cmd_clear,
    evs_cmd_mask_wr,
    evs_cmd_mask_rd,
    evs_cmd_latch_rd,
    evs_cmd_op_done,
    evs_cmd_ident_rd,
    evs_cmd_err_rd
  } evs_cmd_t;

  // Response path states
  typedef enum logic [1:0] {
    evs_rsp_idle,
    evs_rsp_word,
    evs_rsp_ident
  } evs_rsp_st_t;

  // Identification streamer states
  typedef enum logic {
    evs_id_idle,
    evs_id_send
  } evs_ident_st_t;

endpackage

// File: verilog/evs_ident_if.sv
`timescale 1ns/1ps
interface evs_ident_if;
  logic start;
  logic ready;
  logic valid;
  logic last;
  logic [7:0] data;

  modport src (
    input start,
    input ready,
    output valid,
    output last,
    output data
  );

  modport snk (
    output start,
    output ready,
    input valid,
    input last,
    input data
  );
endinterface

// File: verilog/evs_ident_stream.sv
`timescale 1ns/1ps
module evs_ident_stream #(
  parameter int LEN = 4,
  parameter logic [8*LEN-1:0] TEXT = '0
) (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_sync_b,
  // Byte stream towards the response path
  evs_ident_if.src link
);
  import evs_pkg::*;

  localparam int IW = (LEN > 1) ? $clog2(LEN) : 1;
  localparam logic [IW-1:0] LAST_IDX = IW'(LEN - 1);

  // Picks one character, first character at index zero
  function automatic logic [7:0] text_byte(input logic [IW-1:0] idx);
    text_byte = TEXT[8*(LEN-1-int'(idx)) +: 8];
  endfunction

  evs_ident_st_t state_reg, state_next;
  logic [IW-1:0] idx_reg, idx_next;
  logic [7:0] data_reg, data_next;

  // Handshake and position decode
  wire logic sending = (state_reg == evs_id_send);
  wire logic step = sending && link.ready;
  wire logic at_last = (idx_reg == LAST_IDX);
  wire logic [IW-1:0] idx_inc = idx_reg + 1'b1;

  assign link.valid = sending;
  assign link.last = sending && at_last;
  assign link.data = data_reg;

  // Walk the string one character per accepted beat
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    data_next = data_reg;
    case (state_reg)
      evs_id_idle: begin
        if (link.start) begin
          state_next = evs_id_send;
          idx_next = '0;
          data_next = text_byte('0);
        end
      end
      evs_id_send: begin
        if (step && at_last) begin
          state_next = evs_id_idle;
        end else if (step) begin
          idx_next = idx_inc;
          data_next = text_byte(idx_inc);
        end
      end
      default: begin
        state_next = evs_id_idle;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg <= evs_id_idle;
      idx_reg <= '0;
      data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      data_reg <= data_next;
    end
  end
endmodule

// File: verilog/evs_status.sv
// Functional notes
// - Clear empties the error queue and zeroes all event registers but keeps the mask.
// - Clear also drops any pending operation-complete request.
// - The controller writes an 8-bit mask 0 to 255 which resets to 0.
// - The summary bit is the OR of every latched event ANDed with its mask bit.
// - Latch and mask share bits 5,4,3,2,0; bits 7,6,1 are unused.
// - Mask query returns the mask unchanged and has no side effect.
// - Latch query returns the contents and then clears the whole latch.
// - A logged 100-series error sets the command error bit.
// - A logged 200-series error sets the execution error bit.
// - A logged 300-series error sets the device error bit.
// - A current or voltage fault sets the device error and questionable bit.
// - A logged 400-series error sets the query error bit.
// - Operation complete is set only once all earlier work has finished.
// - A pending operation-complete request never stalls later commands.
// - Identification is manufacturer,model,volt,curr,serial,main-flash.
`timescale 1ns/1ps
`include "evs_cfg.svh"
module evs_status #(
  parameter int ERRQ_DEPTH = `EVS_ERRQ_DEPTH,
  // Identification fields, values arbitrary
  parameter logic [8*4-1:0] MFR_TEXT = "ACME",
  parameter logic [8*6-1:0] MODEL_TEXT = "PSU100",
  parameter logic [8*3-1:0] VOLT_TEXT = "100",
  parameter logic [8*1-1:0] CURR_TEXT = "2",
  parameter logic [8*6-1:0] SERIAL_TEXT = "000000",
  parameter logic [8*3-1:0] MAIN_REV_TEXT = "1.0",
  parameter logic [8*3-1:0] FLASH_REV_TEXT = "1.0"
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Commands from the controller
  input wire logic cmd_valid,
  input wire evs_pkg::evs_cmd_t cmd_code,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // Responses to the controller
  output logic rsp_valid,
  output logic [`EVS_ERR_W-1:0] rsp_data,
  output logic rsp_last,
  input wire logic rsp_ready,
  // Event sources
  input wire logic err_log_valid,
  input wire logic [`EVS_ERR_W-1:0] err_log_code,
  input wire logic curr_err_det,
  input wire logic volt_err_det,
  input wire logic ops_busy,
  // Status outputs
  output logic [7:0] latch_value,
  output logic [7:0] mask_value,
  output logic event_summary,
  output logic [1:0] ques_event,
  output logic [$clog2(ERRQ_DEPTH+1)-1:0] err_count,
  output logic op_done_pending,
  output logic status_clear
);
  import evs_pkg::*;

  localparam int EW = `EVS_ERR_W;
  localparam int CW = $clog2(ERRQ_DEPTH+1);
  localparam logic [CW-1:0] DEPTH_C = CW'(ERRQ_DEPTH);
  // Six separators plus the field characters, so no pad byte leads
  localparam int IDENT_LEN = 6 + ($bits(MFR_TEXT) + $bits(MODEL_TEXT) +
    $bits(VOLT_TEXT) + $bits(CURR_TEXT) + $bits(SERIAL_TEXT) +
    $bits(MAIN_REV_TEXT) + $bits(FLASH_REV_TEXT)) / 8;
  localparam logic [8*IDENT_LEN-1:0] IDENT_TEXT = {MFR_TEXT,
    `EVS_IDENT_SEP, MODEL_TEXT, `EVS_IDENT_SEP, VOLT_TEXT,
    `EVS_IDENT_SEP, CURR_TEXT, `EVS_IDENT_SEP, SERIAL_TEXT,
    `EVS_IDENT_SEP, MAIN_REV_TEXT, `EVS_IDENT_JOIN,
    FLASH_REV_TEXT};

  // Error series decode into event bits
  function automatic logic [7:0] series_bits(input logic [EW-1:0] code);
    series_bits = 8'h00;
    if (code >= `EVS_SER_CMD_LO && code < `EVS_SER_EXE_LO) begin
      series_bits[`EVS_CMD_ERR_BIT] = 1'b1;
    end else if (code >= `EVS_SER_EXE_LO && code < `EVS_SER_DEV_LO) begin
      series_bits[`EVS_EXE_ERR_BIT] = 1'b1;
    end else if (code >= `EVS_SER_DEV_LO && code < `EVS_SER_QRY_LO) begin
      series_bits[`EVS_DEV_ERR_BIT] = 1'b1;
    end else if (code >= `EVS_SER_QRY_LO && code < `EVS_SER_QRY_HI) begin
      series_bits[`EVS_QRY_ERR_BIT] = 1'b1;
    end
  endfunction

  // Reset release through two flip-flops
  logic rst_meta_b, rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  evs_rsp_st_t rsp_reg, rsp_next;
  logic [7:0] latch_reg, latch_next;
  logic [7:0] mask_reg, mask_next;
  logic [1:0] ques_reg, ques_next;
  logic pend_reg, pend_next;
  logic [EW-1:0] word_reg, word_next;
  logic [EW-1:0] q_reg [ERRQ_DEPTH];
  logic [EW-1:0] q_next [ERRQ_DEPTH];
  logic [CW-1:0] cnt_reg, cnt_next;

  evs_ident_if ident ();

  // Command decode
  wire logic take = cmd_valid && cmd_ready;
  wire logic take_clear = take && (cmd_code == evs_cmd_clear);
  wire logic take_mask_wr = take && (cmd_code == evs_cmd_mask_wr);
  wire logic take_mask_rd = take && (cmd_code == evs_cmd_mask_rd);
  wire logic take_latch_rd = take && (cmd_code == evs_cmd_latch_rd);
  wire logic take_op_done = take && (cmd_code == evs_cmd_op_done);
  wire logic take_ident = take && (cmd_code == evs_cmd_ident_rd);
  wire logic take_err_rd = take && (cmd_code == evs_cmd_err_rd);
  wire logic take_word = take_mask_rd || take_latch_rd || take_err_rd;

  // Event sources into latch set bits
  wire logic hw_fault = curr_err_det || volt_err_det;
  wire logic op_fire = pend_reg && !ops_busy;
  wire logic [7:0] err_bits =
    err_log_valid ? series_bits(err_log_code) : 8'h00;
  wire logic [7:0] fault_bits =
    hw_fault ? (8'h01 << `EVS_DEV_ERR_BIT) : 8'h00;
  wire logic [7:0] fire_bits =
    op_fire ? (8'h01 << `EVS_OP_DONE_BIT) : 8'h00;
  wire logic [7:0] set_bits =
    (err_bits | fault_bits | fire_bits) & `EVS_USED_BITS;
  wire logic latch_wipe = take_clear || take_latch_rd;

  // Sticky latch, set wins over clear
  assign latch_next =
    (latch_wipe ? 8'h00 : latch_reg) | set_bits;
  assign ques_next = (take_clear ? `EVS_QUES_RESET : ques_reg) |
    {curr_err_det, volt_err_det};
  assign mask_next =
    take_mask_wr ? cmd_data : mask_reg;

  // Operation-complete tracking; a new request re-arms it
  assign pend_next = take_op_done ? 1'b1 :
    ((take_clear || op_fire) ? 1'b0 : pend_reg);

  // Error queue, oldest entry at index zero
  wire logic q_pop = take_err_rd && (cnt_reg != '0);
  wire logic [CW-1:0] cnt_kept = take_clear ? '0 :
    (q_pop ? cnt_reg - 1'b1 : cnt_reg);
  wire logic q_push = err_log_valid && (cnt_kept < DEPTH_C);
  assign cnt_next = q_push ? cnt_kept + 1'b1 : cnt_kept;

  genvar gi;
  generate
    for (gi = 0; gi < ERRQ_DEPTH; gi++) begin : g_queue
      wire logic [EW-1:0] shifted;
      if (gi == ERRQ_DEPTH - 1) begin : g_tail
        assign shifted = q_pop ? '0 : q_reg[gi];
      end else begin : g_body
        assign shifted = q_pop ? q_reg[gi+1] : q_reg[gi];
      end
      assign q_next[gi] = (q_push && cnt_kept == CW'(gi)) ?
        err_log_code : shifted;
    end
  endgenerate

  // Answer word for single-word queries
  wire logic [EW-1:0] err_head = (cnt_reg != '0) ? q_reg[0] : '0;
  always_comb begin
    word_next = word_reg;
    if (take_mask_rd) begin
      word_next = {2'b00, mask_reg};
    end else if (take_latch_rd) begin
      word_next = {2'b00, latch_reg};
    end else if (take_err_rd) begin
      word_next = err_head;
    end
  end

  // Response path sequencing
  always_comb begin
    rsp_next = rsp_reg;
    case (rsp_reg)
      evs_rsp_idle: begin
        if (take_word) begin
          rsp_next = evs_rsp_word;
        end else if (take_ident) begin
          rsp_next = evs_rsp_ident;
        end
      end
      evs_rsp_word: begin
        if (rsp_ready) begin
          rsp_next = evs_rsp_idle;
        end
      end
      evs_rsp_ident: begin
        if (ident.valid && ident.last && rsp_ready) begin
          rsp_next = evs_rsp_idle;
        end
      end
      default: begin
        rsp_next = evs_rsp_idle;
      end
    endcase
  end

  // Handshake and output selection
  assign cmd_ready = (rsp_reg == evs_rsp_idle);
  assign ident.start = take_ident;
  assign ident.ready = (rsp_reg == evs_rsp_ident) && rsp_ready;
  assign rsp_valid = (rsp_reg == evs_rsp_word) ||
    ((rsp_reg == evs_rsp_ident) && ident.valid);
  assign rsp_last = (rsp_reg == evs_rsp_word) ||
    ((rsp_reg == evs_rsp_ident) && ident.last);
  assign rsp_data = (rsp_reg == evs_rsp_ident) ?
    {2'b00, ident.data} : word_reg;
  assign event_summary = |(latch_reg & mask_reg);
  assign latch_value = latch_reg;
  assign mask_value = mask_reg;
  assign ques_event = ques_reg;
  assign err_count = cnt_reg;
  assign op_done_pending = pend_reg;
  assign status_clear = take_clear;

  // Status registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      latch_reg <= `EVS_LATCH_RESET;
      mask_reg <= `EVS_MASK_RESET;
      ques_reg <= `EVS_QUES_RESET;
      pend_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      mask_reg <= mask_next;
      ques_reg <= ques_next;
      pend_reg <= pend_next;
    end
  end

  // Queue and response registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_reg <= '0;
      rsp_reg <= evs_rsp_idle;
      word_reg <= '0;
      for (int i = 0; i < ERRQ_DEPTH; i++) begin
        q_reg[i] <= '0;
      end
    end else begin
      cnt_reg <= cnt_next;
      rsp_reg <= rsp_next;
      word_reg <= word_next;
      q_reg <= q_next;
    end
  end

  evs_ident_stream #(
    .LEN(IDENT_LEN),
    .TEXT(IDENT_TEXT)
  ) u_ident (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .link(ident.src)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_quiet;
    !err_log_valid && !hw_fault && !op_fire;
  endsequence

  sequence s_busy_wait;
    pend_reg && ops_busy && !latch_reg[`EVS_OP_DONE_BIT];
  endsequence

  mask_kept_a: assert property (
    take_clear |=> mask_reg == $past(mask_reg))
    else $error("Clear changed the mask");

  clear_zero_a: assert property (
    (take_clear and s_quiet) |=> (latch_reg == 8'h00) && (ques_reg == 2'h0)
     && (cnt_reg == '0))
    else $error("Clear left status behind");

  clear_pend_a: assert property (
    take_clear |=> !pend_reg)
    else $error("Clear kept a pending completion");

  mask_load_a: assert property (
    take_mask_wr ##1 (!take_mask_wr)[*2] |->
    mask_reg == $past(cmd_data, 2))
    else $error("Mask write not held");

  summary_or_a: assert property (
    ((latch_reg & mask_reg) != 8'h00) == event_summary)
    else $error("Summary bit wrong");

  unused_zero_a: assert property (
    (latch_reg & ~`EVS_USED_BITS) == 8'h00)
    else $error("Unused latch bit set");

  mask_query_a: assert property (
    take_mask_rd |=> rsp_valid && rsp_data == {2'b00, $past(mask_reg)}
    && mask_reg == $past(mask_reg))
    else $error("Mask query wrong");

  latch_query_a: assert property (
    take_latch_rd |=> rsp_data == {2'b00, $past(latch_reg)}
    && latch_reg == $past(set_bits))
    else $error("Latch query wrong");

  cmd_err_a: assert property (
    (err_log_valid && err_log_code >= `EVS_SER_CMD_LO
     && err_log_code < `EVS_SER_EXE_LO) |=> latch_reg[`EVS_CMD_ERR_BIT])
    else $error("Command error bit missed");

  exe_err_a: assert property (
    (err_log_valid && err_log_code >= `EVS_SER_EXE_LO
     && err_log_code < `EVS_SER_DEV_LO) |=> latch_reg[`EVS_EXE_ERR_BIT])
    else $error("Execution error bit missed");

  dev_err_a: assert property (
    (err_log_valid && err_log_code >= `EVS_SER_DEV_LO
     && err_log_code < `EVS_SER_QRY_LO) |=> latch_reg[`EVS_DEV_ERR_BIT])
    else $error("Device error bit missed");

  fault_dev_a: assert property (
    curr_err_det |=> latch_reg[`EVS_DEV_ERR_BIT]
    && ques_reg[`EVS_QUES_CURR_BIT])
    else $error("Current fault not latched");

  qry_err_a: assert property (
    (err_log_valid && err_log_code >= `EVS_SER_QRY_LO
     && err_log_code < `EVS_SER_QRY_HI) |=> latch_reg[`EVS_QRY_ERR_BIT])
    else $error("Query error bit missed");

  op_wait_a: assert property (
    s_busy_wait |=> !latch_reg[`EVS_OP_DONE_BIT])
    else $error("Completion set while busy");

  op_fire_a: assert property (
    (pend_reg && !ops_busy) |=> latch_reg[`EVS_OP_DONE_BIT])
    else $error("Completion not set when idle");

  no_stall_a: assert property (
    take_op_done |=> cmd_ready ##1 cmd_ready)
    else $error("Completion request stalled commands");

  ident_first_a: assert property (
    take_ident |=> rsp_valid
    && rsp_data[7:0] == IDENT_TEXT[8*IDENT_LEN-1 -: 8])
    else $error("Identification start wrong");
endmodule

// File: testbench/evs_ctrl_model.sv
`timescale 1ns/1ps
module evs_ctrl_model (
  // Clock
  input wire logic clk,
  // Command side
  output evs_pkg::evs_cmd_t cmd_code,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire logic cmd_ready,
  // Response side
  output logic rsp_ready,
  // Set when a command is never taken
  output logic timed_out
);
  import evs_pkg::*;
  logic slow;

  // Idle levels at time zero
  initial begin
    slow = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = evs_cmd_none;
    cmd_data = 8'h00;
    rsp_ready = 1'b1;
    timed_out = 1'b0;
  end

  // Accept beats at once, or stall at random when slow
  always @(posedge clk) begin
    rsp_ready <= slow ? 1'($urandom % 2) : 1'b1;
  end

  // Hold a command until taken, then scramble the released lines
  task automatic issue(input evs_cmd_t c, input logic [7:0] d);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 200) begin
      n++;
      @(negedge clk);
    end
    if (n >= 200) timed_out = 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= evs_cmd_t'(~c);
    cmd_data <= ~d;
  endtask
endmodule

// File: testbench/evs_status_test.sv
`timescale 1ns/1ps
module evs_status_test;
  import evs_pkg::*;
  // Identification fields, values arbitrary
  localparam logic [31:0] MFR = "ZETA";
  localparam logic [47:0] MODEL = "PS0042";
  localparam logic [23:0] VOLT = "050";
  localparam logic [7:0] CURR = "8";
  localparam logic [47:0] SER = "314159";
  localparam logic [23:0] REV_M = "2.3";
  localparam logic [23:0] REV_F = "4.5";
  localparam logic [255:0] IDENT = {MFR, ",", MODEL, ",", VOLT, ",",
    CURR, ",", SER, ",", REV_M, "-", REV_F};
  logic clk, rst_b, err_log_valid, curr_err_det, volt_err_det, ops_busy;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready, timed_out;
  logic event_summary, op_done_pending, status_clear;
  evs_cmd_t cmd_code;
  logic [7:0] cmd_data, latch_value, mask_value, v, ev;
  logic [9:0] rsp_data, err_log_code, code;
  logic [1:0] ques_event;
  logic [2:0] err_count;
  logic [10:0] exp_q[$];
  int n_errors = 0;
  int tests_run = 0;
  int n_clr = 0;

  evs_status #(.MFR_TEXT(MFR), .MODEL_TEXT(MODEL), .VOLT_TEXT(VOLT),
    .CURR_TEXT(CURR), .SERIAL_TEXT(SER), .MAIN_REV_TEXT(REV_M),
    .FLASH_REV_TEXT(REV_F)) dut (.clk, .rst_b, .cmd_valid, .cmd_code,
    .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready,
    .err_log_valid, .err_log_code, .curr_err_det, .volt_err_det,
    .ops_busy, .latch_value, .mask_value, .event_summary, .ques_event,
    .err_count, .op_done_pending, .status_clear);

  evs_ctrl_model ctl (.clk, .cmd_code, .cmd_valid, .cmd_data,
    .cmd_ready, .rsp_ready, .timed_out);

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic hang;
    n_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: beat %h, want %h", $time, got, exp);
    end
  endtask

  // Match each accepted beat against the oldest note
  always @(posedge clk) begin
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (exp_q.size() == 0)
        chk_rsp({rsp_last, rsp_data}, 11'h7ff);
      else
        chk_rsp({rsp_last, rsp_data}, exp_q.pop_front());
    end
    if (status_clear === 1'b1) n_clr++;
  end

  always @(posedge timed_out) hang();

  // Wait until every noted answer has arrived
  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || rsp_valid !== 1'b0) && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) hang();
  endtask

  task automatic query(input evs_cmd_t c, input logic [9:0] d);
    exp_q.push_back({1'b1, d});
    ctl.issue(c, 8'h00);
    drain();
  endtask

  task automatic pulse_err(input logic [9:0] c);
    @(posedge clk);
    err_log_valid <= 1'b1;
    err_log_code <= c;
    @(posedge clk);
    err_log_valid <= 1'b0;
    err_log_code <= ~c;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    err_log_valid = 1'b0;
    err_log_code = 10'h000;
    curr_err_det = 1'b0;
    volt_err_det = 1'b0;
    ops_busy = 1'b0;
    void'($urandom(67481));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_val(mask_value, 8'h00);
    chk_val(latch_value, 8'h00);
    query(evs_cmd_mask_rd, 10'h000);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h3c : 8'($urandom);
      ctl.issue(evs_cmd_mask_wr, v);
      query(evs_cmd_mask_rd, {2'h0, v});
      query(evs_cmd_mask_rd, {2'h0, v});
      chk_val(latch_value, 8'h00);
    end
    $display("test mask write and read done");
    ev = 8'h00;
    for (int i = 0; i < 4; i++) begin
      code = 10'(100 * (i + 1) + ((i % 2) ? 99 : $urandom % 100));
      pulse_err(code);
      ev = ev | (8'h20 >> i);
      @(negedge clk);
      chk_val(latch_value, ev);
    end
    $display("test error series done");
    for (int i = 0; i < 8; i++) begin
      ctl.issue(evs_cmd_mask_wr, 8'h01 << i);
      @(negedge clk);
      chk_val(8'(event_summary), 8'(ev[i]));
      chk_val(latch_value, ev);
    end
    $display("test event summary done");
    query(evs_cmd_latch_rd, {2'h0, ev});
    chk_val(latch_value, 8'h00);
    query(evs_cmd_latch_rd, 10'h000);
    @(posedge clk);
    curr_err_det <= 1'b1;
    @(posedge clk);
    curr_err_det <= 1'b0;
    volt_err_det <= 1'b1;
    @(posedge clk);
    volt_err_det <= 1'b0;
    @(negedge clk);
    chk_val(latch_value, 8'h08);
    chk_val(8'(ques_event), 8'h03);
    $display("test fault detection done");
    @(posedge clk);
    ops_busy <= 1'b1;
    ctl.issue(evs_cmd_op_done, 8'h00);
    ctl.issue(evs_cmd_mask_wr, 8'h01);
    query(evs_cmd_mask_rd, 10'h001);
    chk_val(8'(op_done_pending), 8'h01);
    chk_val(latch_value, 8'h08);
    @(posedge clk);
    ops_busy <= 1'b0;
    @(negedge clk);
    chk_val(latch_value, 8'h08);
    @(negedge clk);
    chk_val(latch_value, 8'h09);
    chk_val(8'(op_done_pending), 8'h00);
    chk_val(8'(event_summary), 8'h01);
    $display("test operation complete done");
    @(posedge clk);
    ops_busy <= 1'b1;
    ctl.issue(evs_cmd_op_done, 8'h00);
    @(negedge clk);
    chk_val(8'(err_count), 8'h04);
    ctl.issue(evs_cmd_clear, 8'h00);
    @(negedge clk);
    chk_val(latch_value, 8'h00);
    chk_val(8'(ques_event), 8'h00);
    chk_val(8'(err_count), 8'h00);
    chk_val(mask_value, 8'h01);
    chk_val(8'(op_done_pending), 8'h00);
    @(posedge clk);
    ops_busy <= 1'b0;
    repeat (3) @(negedge clk);
    chk_val(latch_value, 8'h00);
    query(evs_cmd_err_rd, 10'h000);
    chk_val(8'(n_clr), 8'h01);
    $display("test clear status done");
    ctl.slow = 1'b1;
    for (int i = 31; i >= 0; i--)
      exp_q.push_back({i == 0, 2'h0, IDENT[8*i +: 8]});
    ctl.issue(evs_cmd_ident_rd, 8'h00);
    drain();
    ctl.slow = 1'b0;
    $display("test identification done");
    print_verdict();
  end
endmodule
